//--- core/mcu_instruction_execute.sv
// Instruction execution core with file registers, stack and APB access
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "exec_consts.svh"

module mcu_instruction_execute (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Asynchronous reset
  input wire exec_pkg::apb_req_t apb_req, // APB request from master
  output exec_pkg::apb_rsp_t apb_rsp, // APB answer
  output logic [12:0] prog_addr, // Program memory address
  input wire logic [13:0] prog_data, // Instruction word at prog_addr
  output logic watchdog_kick, // Pulse when the watchdog is cleared
  output logic irq_enable // Global interrupt enable level
);
  import exec_pkg::*;

  // Register map, one 32-bit word per register, unused bits read as zero:
  //   0x00 control: bit 0 starts and stops the core
  //   0x04 status: accumulator in bits 7:0, then carry, half carry, zero,
  //        watchdog expiry, sleep entry and interrupt enable from bit 8 up
  //   0x08 program counter, 13 bits; a write also drops a pending dead cycle
  //   0x0c program page latch; bits 4:3 become counter bits 12:11 on a branch
  //   0x10 file pointer used by the data word below
  //   0x14 file register at the file pointer
  // Any other address answers with the error flag and reads as zero.
  //
  // Software is meant to load registers while the core is stopped. A write
  // that lands on an execute edge wins over the instruction's own result
  // for the fields it writes only, so a racing call can keep its stack push yet lose its jump.
  //
  // All state sits in one packed struct: accumulator, flags, counter, stack,
  // phase counter and the 128-byte file space. The file space is plain
  // storage here; no special register is mapped into it.

  state_t s_q;
  state_t s_d;
  logic [13:0] inst;
  logic [6:0] fa;
  logic [7:0] fval;
  logic [7:0] lit;
  logic [7:0] res;
  logic [8:0] sum;
  logic [4:0] hsum;
  logic [12:0] pc_inc;
  logic wr_f;
  logic wr_a;
  logic set_z;
  logic add_op;
  logic [7:0] addend;
  logic setup;
  logic access;

  assign prog_addr = s_q.pc;
  assign watchdog_kick = s_q.kick;
  assign irq_enable = s_q.global_irq_enable;
  assign apb_rsp.prdata = s_q.prdata;
  assign apb_rsp.pslverr = s_q.pslverr;
  // Read data is captured in the setup cycle, so the access phase never waits
  assign apb_rsp.pready = apb_req.psel & apb_req.penable;

  // Timing of one instruction:
  //   the phase counter steps 0, 1, 2, 3 while the core runs
  //   the word on prog_data is executed at the edge ending phase 3
  //   results and the next fetch address appear right after that edge
  // Program memory must answer in the same clock, since the word is read
  // combinationally from the fetch address.
  // Stopping the core returns the phase counter to zero, so a restart
  // always begins with a full instruction cycle.
  //
  // A branch or a true skip leaves a dead cycle behind it:
  //   dummy marks that the next instruction cycle executes as nothing
  //   dummy_hold keeps the counter at the branch target through that cycle,
  //   so the target is fetched again and executed one cycle later
  // For a skip the counter steps on, past the word that was discarded.
  always_comb begin
    s_d = s_q;
    inst = prog_data;
    fa = inst[6:0];
    fval = s_q.files[fa];
    lit = inst[7:0];
    res = `BYTE_ZERO;
    wr_f = 1'b0;
    wr_a = 1'b0;
    set_z = 1'b0;
    add_op = 1'b0;
    addend = fval;
    pc_inc = s_q.pc + `PC_ONE;
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable;
    s_d.kick = 1'b0;

    // The prescaler divides by 256 and the counter by 256 again, so a full
    // timeout is 65536 clocks; software must kick well inside that span.
    // The expiry flag is active low: it drops when the counter wraps.
    // Watchdog runs on every clock; a wrap drops the no-timeout flag
    s_d.wdt_pre = s_q.wdt_pre + `BYTE_ONE;
    if (s_q.wdt_pre == `BYTE_MAX) begin
      s_d.watchdog_counter = s_q.watchdog_counter + `BYTE_ONE;
      if (s_q.watchdog_counter == `BYTE_MAX) begin
        s_d.watchdog_expiry_flag = 1'b0;
      end
    end

    s_d.phase = s_q.run ? s_q.phase + `PHASE_ONE : `RST_PHASE;
    if (s_q.run && s_q.phase == `PHASE_EXEC) begin
      s_d.pc = pc_inc;
      if (s_q.dummy) begin
        // Second cycle of a branch or true skip executes as a no-operation
        s_d.dummy = 1'b0;
        s_d.dummy_hold = 1'b0;
        if (s_q.dummy_hold) begin
          s_d.pc = s_q.pc;
        end
      end else begin
        // Top two bits pick the class: file byte, file bit, branch or literal.
        // File operations read the addressed byte even when they only write it.
        case (inst[13:12])
          `CLS_BYTE: begin
            case (inst[11:8])
              `OP_MISC: begin
                // Bit 7 set stores the accumulator; two fixed words return from
                // interrupt and kick the watchdog; all else is a no-operation.
                if (inst[7]) begin
                  res = s_q.acc;
                  wr_f = 1'b1;
                end else if (lit == `ENC_IRET) begin
                  s_d.sp = s_q.sp - `SP_ONE;
                  s_d.pc = s_q.stack[s_d.sp];
                  s_d.global_irq_enable = 1'b1;
                  s_d.dummy = 1'b1;
                  s_d.dummy_hold = 1'b1;
                end else if (lit == `ENC_KICK) begin
                  s_d.watchdog_counter = `BYTE_ZERO;
                  s_d.wdt_pre = `BYTE_ZERO;
                  s_d.watchdog_expiry_flag = 1'b1;
                  s_d.sleep_entry_flag = 1'b1;
                  s_d.kick = 1'b1;
                end
              end
              `OP_CLEAR: begin
                res = `BYTE_ZERO;
                wr_f = inst[7];
                wr_a = ~inst[7];
                set_z = 1'b1;
              end
              `OP_ACC_OR_FILE: begin
                res = s_q.acc | fval;
                set_z = 1'b1;
                wr_f = inst[7];
                wr_a = ~inst[7];
              end
              `OP_ACC_AND_FILE: begin
                res = s_q.acc & fval;
                set_z = 1'b1;
                wr_f = inst[7];
                wr_a = ~inst[7];
              end
              `OP_ACC_PLUS_FILE: begin
                add_op = 1'b1;
                wr_f = inst[7];
                wr_a = ~inst[7];
              end
              `OP_COPY_FILE_OP: begin
                res = fval;
                set_z = 1'b1;
                wr_f = inst[7];
                wr_a = ~inst[7];
              end
              `OP_INVERT_FILE_OP: begin
                res = ~fval;
                set_z = 1'b1;
                wr_f = inst[7];
                wr_a = ~inst[7];
              end
              // The skip forms share the arithmetic but leave every flag alone.
              `OP_FILE_PLUS_ONE, `OP_INC_SKIP_ZERO: begin
                res = fval + `BYTE_ONE;
                set_z = (inst[11:8] == `OP_FILE_PLUS_ONE);
                wr_f = inst[7];
                wr_a = ~inst[7];
                if (inst[11:8] == `OP_INC_SKIP_ZERO && res == `BYTE_ZERO) begin
                  s_d.dummy = 1'b1;
                end
              end
              `OP_FILE_MINUS_ONE, `OP_DEC_SKIP_ZERO: begin
                res = fval - `BYTE_ONE;
                set_z = (inst[11:8] == `OP_FILE_MINUS_ONE);
                wr_f = inst[7];
                wr_a = ~inst[7];
                if (inst[11:8] == `OP_DEC_SKIP_ZERO && res == `BYTE_ZERO) begin
                  s_d.dummy = 1'b1;
                end
              end
              // Carry goes in at bit 0 and bit 7 comes out into carry.
              `OP_RLF: begin
                res = {fval[6:0], s_q.carry};
                s_d.carry = fval[7];
                wr_f = inst[7];
                wr_a = ~inst[7];
              end
              default: begin
                // Instructions outside this core execute as no-operations
                res = `BYTE_ZERO;
              end
            endcase
          end
          // Bit operations touch no flag; the tests only decide the dead cycle.
          `CLS_BIT: begin
            res = fval;
            case (inst[11:10])
              `OP_BCLR: begin
                res[inst[9:7]] = 1'b0;
                wr_f = 1'b1;
              end
              `OP_BSET: begin
                res[inst[9:7]] = 1'b1;
                wr_f = 1'b1;
              end
              `OP_BTLOW: begin
                s_d.dummy = ~fval[inst[9:7]];
              end
              default: begin
                s_d.dummy = fval[inst[9:7]];
              end
            endcase
          end
          `CLS_JUMP: begin
            // Bit 11 clear is a call; the stack has eight entries and its
            // pointer wraps silently, so a ninth nested call overwrites the oldest.
            if (!inst[11]) begin
              s_d.stack[s_q.sp] = pc_inc;
              s_d.sp = s_q.sp + `SP_ONE;
            end
            s_d.pc = {s_q.program_page_latch[4:3], inst[10:0]};
            s_d.dummy = 1'b1;
            s_d.dummy_hold = 1'b1;
          end
          default: begin
            // Literal forms target the accumulator; unknown ones write nothing.
            wr_a = 1'b1;
            if (inst[11:8] == `OP_ACC_OR_LITERAL) begin
              res = s_q.acc | lit;
              set_z = 1'b1;
            end else if (inst[11:8] == `OP_ACC_AND_LITERAL) begin
              res = s_q.acc & lit;
              set_z = 1'b1;
            end else if (inst[11:9] == `OP_ACC_PLUS_LITERAL) begin
              add_op = 1'b1;
              addend = lit;
            end else if (inst[11:10] == `OP_LOAD_LITERAL_ACC) begin
              res = lit;
            end else begin
              wr_a = 1'b0;
            end
          end
        endcase
      end
    end

    // One adder serves both add forms; half carry is the carry out of the
    // low nibble, taken from a separate 5-bit sum to keep it readable.
    sum = {1'b0, s_q.acc} + {1'b0, addend};
    hsum = {1'b0, s_q.acc[3:0]} + {1'b0, addend[3:0]};
    if (add_op) begin
      res = sum[7:0];
      s_d.carry = sum[8];
      s_d.half_carry_flag = hsum[4];
      set_z = 1'b1;
    end
    // Zero follows the routed result, whether it goes to accumulator or file.
    if (set_z) begin
      s_d.zero = (res == `BYTE_ZERO);
    end
    if (wr_f) begin
      s_d.files[fa] = res;
    end
    if (wr_a) begin
      s_d.acc = res;
    end

    // APB: read data captured at setup, writes take effect in the access phase
    // Reading a register has no side effect, so early capture is harmless.
    if (setup) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      if (apb_req.paddr == `OFF_CTRL) begin
        s_d.prdata[0] = s_q.run;
      end else if (apb_req.paddr == `OFF_STATUS) begin
        s_d.prdata[7:0] = s_q.acc;
        s_d.prdata[`ST_C] = s_q.carry;
        s_d.prdata[`ST_DC] = s_q.half_carry_flag;
        s_d.prdata[`ST_Z] = s_q.zero;
        s_d.prdata[`ST_TO] = s_q.watchdog_expiry_flag;
        s_d.prdata[`ST_PD] = s_q.sleep_entry_flag;
        s_d.prdata[`ST_GIE] = s_q.global_irq_enable;
      end else if (apb_req.paddr == `OFF_PC) begin
        s_d.prdata[12:0] = s_q.pc;
      end else if (apb_req.paddr == `OFF_PAGE) begin
        s_d.prdata[7:0] = s_q.program_page_latch;
      end else if (apb_req.paddr == `OFF_FADDR) begin
        s_d.prdata[6:0] = s_q.file_addr;
      end else if (apb_req.paddr == `OFF_FDATA) begin
        s_d.prdata[7:0] = s_q.files[s_q.file_addr];
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    // A bus write lands after execution, so software wins a same-cycle clash
    if (access && apb_req.pwrite) begin
      if (apb_req.paddr == `OFF_CTRL) begin
        s_d.run = apb_req.pwdata[0];
      end else if (apb_req.paddr == `OFF_STATUS) begin
        s_d.acc = apb_req.pwdata[7:0];
        s_d.carry = apb_req.pwdata[`ST_C];
        s_d.half_carry_flag = apb_req.pwdata[`ST_DC];
        s_d.zero = apb_req.pwdata[`ST_Z];
        s_d.global_irq_enable = apb_req.pwdata[`ST_GIE];
      end else if (apb_req.paddr == `OFF_PC) begin
        s_d.pc = apb_req.pwdata[12:0];
        s_d.dummy = 1'b0;
        s_d.dummy_hold = 1'b0;
      end else if (apb_req.paddr == `OFF_PAGE) begin
        s_d.program_page_latch = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == `OFF_FADDR) begin
        s_d.file_addr = apb_req.pwdata[6:0];
      end else if (apb_req.paddr == `OFF_FDATA) begin
        s_d.files[s_q.file_addr] = apb_req.pwdata[7:0];
      end
    end
  end

  // Reset leaves the core stopped at address zero with both watchdog status
  // flags high, as after a clean power-up; everything else starts at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.watchdog_expiry_flag <= 1'b1;
      s_q.sleep_entry_flag <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : mcu_instruction_execute

//--- core/exec_consts.svh
// Named constants for the instruction execution core
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// Register offsets on the APB bus (byte addresses, one word each)
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_PC 12'h008
`define OFF_PAGE 12'h00c
`define OFF_FADDR 12'h010
`define OFF_FDATA 12'h014

// Status register field positions
`define ST_C 8
`define ST_DC 9
`define ST_Z 10
`define ST_TO 11
`define ST_PD 12
`define ST_GIE 13

// Reset values
`define RST_PC 13'h0000
`define RST_BYTE 8'h00
`define RST_SP 3'h0
`define RST_PHASE 2'h0

// Timing: one instruction cycle is four clock phases, executed in the last
`define PHASE_ONE 2'h1
`define PHASE_EXEC 2'h3
`define PC_ONE 13'h0001
`define SP_ONE 3'h1
`define BYTE_ONE 8'h01
`define BYTE_ZERO 8'h00
`define BYTE_MAX 8'hff

// Instruction classes, bits 13:12
`define CLS_BYTE 2'h0
`define CLS_BIT 2'h1
`define CLS_JUMP 2'h2
`define CLS_LIT 2'h3

// Byte-oriented opcodes, bits 11:8
`define OP_MISC 4'h0
`define OP_CLEAR 4'h1
`define OP_FILE_MINUS_ONE 4'h3
`define OP_ACC_OR_FILE 4'h4
`define OP_ACC_AND_FILE 4'h5
`define OP_ACC_PLUS_FILE 4'h7
`define OP_COPY_FILE_OP 4'h8
`define OP_INVERT_FILE_OP 4'h9
`define OP_FILE_PLUS_ONE 4'ha
`define OP_DEC_SKIP_ZERO 4'hb
`define OP_RLF 4'hd
`define OP_INC_SKIP_ZERO 4'hf

// Fixed encodings in the misc group, bits 7:0
`define ENC_IRET 8'h09
`define ENC_KICK 8'h64

// Bit-oriented opcodes, bits 11:10
`define OP_BCLR 2'h0
`define OP_BSET 2'h1
`define OP_BTLOW 2'h2
`define OP_BTHIGH 2'h3

// Literal opcodes
`define OP_ACC_OR_LITERAL 4'h8
`define OP_ACC_AND_LITERAL 4'h9
`define OP_ACC_PLUS_LITERAL 3'h7
`define OP_LOAD_LITERAL_ACC 2'h0

`endif

//--- core/exec_pkg.sv
// Types shared by the instruction execution core
package exec_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [12:0] pc;
    logic [7:0] acc;
    logic carry;
    logic half_carry_flag;
    logic zero;
    logic watchdog_expiry_flag;
    logic sleep_entry_flag;
    logic global_irq_enable;
    logic [7:0] program_page_latch;
    logic [1:0] phase;
    logic run;
    logic dummy;
    logic dummy_hold;
    logic kick;
    logic [7:0] wdt_pre;
    logic [7:0] watchdog_counter;
    logic [6:0] file_addr;
    logic [31:0] prdata;
    logic pslverr;
    logic [2:0] sp;
    logic [7:0][12:0] stack;
    logic [127:0][7:0] files;
  } state_t;

endpackage : exec_pkg

//--- tb/prog_rom.sv
// Program memory model feeding the core
`timescale 1ns/1ps
module prog_rom (
  input wire logic [12:0] addr, // Fetch address
  output logic [13:0] data // Word, same cycle
);
  // Only 64 words: upper counter bits alias, so paged targets fold back
  logic [13:0] mem [64];
  assign data = mem[addr[5:0]];
endmodule : prog_rom

//--- tb/exec_asserts.sv
// Port assertions for the execution core
`timescale 1ns/1ps
`include "exec_consts.svh"
module exec_asserts (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire exec_pkg::apb_req_t apb_req, // Request
  input wire exec_pkg::apb_rsp_t apb_rsp, // Answer
  input wire logic [12:0] prog_addr, // Counter
  input wire logic [13:0] prog_data, // Word
  input wire logic watchdog_kick, // Kick
  input wire logic irq_enable // Irq enable
);
  import exec_pkg::*;
  logic acc_c, pc_wr, st_wr, bad, jmp, iret;
  logic [10:0] tgt;
  assign acc_c = apb_req.psel & apb_req.penable;
  assign pc_wr = acc_c & apb_req.pwrite & (apb_req.paddr == `OFF_PC);
  assign st_wr = acc_c & apb_req.pwrite & (apb_req.paddr == `OFF_STATUS);
  assign bad = (apb_req.paddr > `OFF_FDATA) | (apb_req.paddr[1:0] != 2'h0);
  assign jmp = prog_data[13:12] == `CLS_JUMP;
  assign iret = prog_data == 14'h0009;
  assign tgt = prog_data[10:0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Bus writes to the counter are excluded: they move it at any edge
  chk_zero_wait: assert property (acc_c |-> apb_rsp.pready)
    else $error("pready low");
  chk_bad_addr: assert property (acc_c && bad |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access");
  chk_kick_cause: assert property (watchdog_kick |-> $past(prog_data) == 14'h0064 ##1 !watchdog_kick)
    else $error("bad kick");
  chk_cycle_hold: assert property ($changed(prog_addr) && !$past(pc_wr) |=> ($stable(prog_addr) || $past(pc_wr)) [*3])
    else $error("cycle too short");
  chk_jump_target: assert property ($changed(prog_addr) && !$past(pc_wr) && $past(jmp) |-> prog_addr[10:0] == $past(tgt))
    else $error("bad target");
  chk_jump_dummy: assert property ($changed(prog_addr) && !$past(pc_wr) && $past(jmp) |=> $stable(prog_addr) [*7])
    else $error("no dummy cycle");
  chk_step_skip: assert property ($changed(prog_addr) && !$past(pc_wr) && !$past(jmp) && !$past(iret)
    |-> prog_addr == $past(prog_addr) + 13'h1 || prog_addr == $past(prog_addr) + 13'h2)
    else $error("bad step");
  chk_gie_rise: assert property ($rose(irq_enable) |-> $past(iret) || $past(iret, 2) || $past(st_wr) || $past(st_wr, 2))
    else $error("irq enable rose");
endmodule : exec_asserts
bind mcu_instruction_execute exec_asserts u_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .prog_addr(prog_addr), .prog_data(prog_data),
  .watchdog_kick(watchdog_kick), .irq_enable(irq_enable));

//--- tb/mcu_instruction_execute_test.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
`include "exec_consts.svh"
module mcu_instruction_execute_test;
  import exec_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [12:0] prog_addr;
  logic [13:0] prog_data, w;
  logic watchdog_kick, irq_enable, d, skip;
  logic gie_exp = 1'b0;
  logic [32:0] expq[$];
  logic [13:0] p[$];
  logic [10:0] s, se, r;
  logic [7:0] v, ve;
  logic [6:0] f;
  logic [3:0] op;
  logic [2:0] b;
  logic [1:0] k;
  logic [3:0] fops [9] = '{4'h7, 4'h5, 4'h4, 4'h9, 4'ha, 4'h3, 4'h8, 4'hd, 4'h1};
  logic [5:0] lhi [4] = '{6'h3e, 6'h39, 6'h38, 6'h30};
  logic [3:0] lops [4] = '{4'h7, 4'h5, 4'h4, 4'h0};
  int n_errors = 0;
  int total_checks = 0;
  int kicks = 0;
  always #12.5 pclk = ~pclk;
  mcu_instruction_execute dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .prog_addr(prog_addr), .prog_data(prog_data), .watchdog_kick(watchdog_kick),
    .irq_enable(irq_enable));
  prog_rom u_rom (.addr(prog_addr), .data(prog_data));
  task automatic results;
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    @(posedge pclk);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= dat;
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Status image is {z, dc, c, acc}, matching its bit positions
  task automatic set(input logic [10:0] st, input logic [6:0] fa, input logic [7:0] fv);
    bus(1'b1, `OFF_STATUS, {21'h0, st});
    bus(1'b1, `OFF_FADDR, {25'h0, fa});
    bus(1'b1, `OFF_FDATA, {24'h0, fv});
  endtask : set
  task automatic chk(input logic [10:0] st, input logic [6:0] fa, input logic [7:0] fv);
    rd(`OFF_STATUS, {19'h0, gie_exp, 2'h3, st});
    bus(1'b1, `OFF_FADDR, {25'h0, fa});
    rd(`OFF_FDATA, {25'h0, fv});
  endtask : chk
  // The program parks on a jump to itself, so the wait need not be exact
  task automatic run;
    p.push_back(14'h2800 | 14'(p.size()));
    foreach (p[j]) u_rom.mem[j] = p[j];
    bus(1'b1, `OFF_PC, 32'h0);
    bus(1'b1, `OFF_CTRL, 32'h1);
    repeat (100) @(posedge pclk);
    bus(1'b1, `OFF_CTRL, 32'h0);
  endtask : run
  function automatic logic [10:0] alu(input logic [3:0] o, input logic [10:0] st, input logic [7:0] x);
    logic [8:0] sum;
    logic [10:0] q;
    sum = st[7:0] + x;
    q = st;
    case (o)
      4'h7: q = {sum[7:0] == 8'h0, {1'b0, st[3:0]} + x[3:0] > 5'hf, sum};
      4'h5: q[7:0] = st[7:0] & x;
      4'h4: q[7:0] = st[7:0] | x;
      4'h9: q[7:0] = ~x;
      4'ha: q[7:0] = x + 8'h1;
      4'h3: q[7:0] = x - 8'h1;
      4'hd: q[8:0] = {x, st[8]};
      4'h1: q[7:0] = 8'h0;
      default: q[7:0] = x;
    endcase
    if (o != 4'hd && o != 4'h0)
      q[10] = q[7:0] == 8'h0;
    return q;
  endfunction : alu
  always @(posedge pclk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
      cmp("read", expq.pop_front(), {rsp.pslverr, rsp.prdata});
    if (watchdog_kick === 1'b1)
      kicks++;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    results();
  end
  initial begin
    void'($urandom(16));
    for (int i = 0; i < 64; i++)
      u_rom.mem[i] = 14'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset image of every register, then one unmapped word
    for (int i = 0; i < 7; i++)
      rd(12'(i * 4), i == 6 ? 33'h100000000 : i == 1 ? 33'h1800 : 33'h0);
    for (int i = 0; i < 54; i++) begin
      s = 11'($urandom);
      f = 7'($urandom);
      v = 8'($urandom);
      b = 3'($urandom);
      d = i[0];
      skip = 1'b0;
      se = s;
      ve = v;
      if (i < 18) begin
        op = fops[i / 2];
        w = {2'h0, op, d, f};
        r = alu(op, s, v);
        se = d ? {r[10:8], s[7:0]} : r;
        ve = d ? r[7:0] : v;
      end else if (i < 30) begin
        w = {lhi[i % 4], v};
        se = alu(lops[i % 4], s, v);
      end else if (i < 46) begin
        w = {3'h2, i[3], b, f};
        ve[b] = i[3];
      end else begin
        k = i[2:1];
        if (k < 2)
          v[b] = d;
        else
          v = d ? (k == 2 ? 8'hff : 8'h01) : 8'h07;
        ve = k == 2 ? v + 8'h1 : k == 3 ? v - 8'h1 : v;
        w = k < 2 ? {3'h3, k[0], b, f} : {2'h0, k[0] ? 4'hb : 4'hf, 1'b1, f};
        skip = k == 0 ? !d : k == 1 ? d : ve == 8'h0;
      end
      if (!skip)
        se = alu(4'h7, se, 8'h1);
      set(s, f, v);
      p = {w, 14'h3e01};
      run();
      chk(se, f, ve);
    end
    bus(1'b1, `OFF_PAGE, 32'h8);
    s = {3'h0, 8'($urandom)};
    set(s, 7'h0, 8'h0);
    p = {14'h2004, 14'h3e01, 14'h2802, 14'h0, 14'h0064, 14'h3e02, 14'h0009};
    run();
    gie_exp = 1'b1;
    chk(alu(4'h7, alu(4'h7, s, 8'h2), 8'h1), 7'h0, 8'h0);
    rd(`OFF_PC, 33'h802);
    cmp("kicks", 33'h1, 33'(kicks));
    cmp("irq_enable", 33'h1, {32'h0, irq_enable});
    results();
  end
endmodule : mcu_instruction_execute_test
